/* include/qtimer_pkg.sv */
// Function
// - Four independent timers share one counting clock, each with its own mode.
// - Timer 0 output rising edge raises interrupt eight; no pin for timer 0.
// - Timer 1 rising edge requests refresh when enabled; disabled after reset.
// - Timer 2 pin is two-way; a low level on it raises interrupt three.
// - Timer 3 output edge detector raises interrupt zero; inverted output drives a pin.
// - All commands and count data move over an 8-bit bus with read/write decode.
// - Control word one programs timers 0 to 2; control word two programs timer 3.
// - Latched status holds control word, output level and null count flag.
// - Each counting element is a 16-bit presettable synchronous down counter.
// - Output latches load from the count on a latch command and hold until read.
// - One byte drives the bus per read; unlatched reads take the counting element directly.
// - Count writes fill two hold bytes singly; loading moves both together.
// - Programming a counter clears both count hold bytes.
// - The host never writes the counting element directly.
// - External timer pins carry the inverse of the internal output.
// - Gate sampled on reference rising edge; loads and decrements on falling edge.
// - Gates 0 and 1 tied high; gates 2 and 3 from control bits 0 and 6, low at reset.
package qtimer_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          NUM_TIMERS    = 4;
    localparam int          NUM_EV        = 4;
    // Register byte addresses; counter n data port at 4*n
    localparam logic [7:0]  OFF_CNT_LAST  = 8'h0c;
    localparam logic [7:0]  OFF_CW1       = 8'h10;
    localparam logic [7:0]  OFF_CW2       = 8'h14;
    localparam logic [7:0]  OFF_CTRL      = 8'h18;
    localparam logic [7:0]  OFF_INT_STAT  = 8'h1c;
    localparam logic [7:0]  OFF_INT_EN    = 8'h20;
    localparam logic [7:0]  OFF_INT_CLR   = 8'h24;
    // Control word fields
    localparam int          CW_SEL_LO     = 6;
    localparam int          CW_RW_LO      = 4;
    localparam int          CW_MODE_LO    = 1;
    localparam logic [1:0]  SEL_READBACK  = 2'h3;
    localparam logic [1:0]  RW_LATCH      = 2'h0;
    localparam logic [1:0]  RW_LOW        = 2'h1;
    localparam logic [1:0]  RW_HIGH       = 2'h2;
    localparam logic [1:0]  RW_BOTH       = 2'h3;
    localparam logic [2:0]  MODE_TERMINAL = 3'h0;
    localparam int          RB_NCOUNT     = 5;
    localparam int          RB_NSTAT      = 4;
    // Control port fields
    localparam int          CTRL_GATE2    = 0;
    localparam int          CTRL_REF_EN   = 1;
    localparam int          CTRL_GATE3    = 6;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    // Interrupt event bits
    localparam int          EV_INTERRUPT_REQUEST_EIGHT       = 0;
    localparam int          EV_REFRESH    = 1;
    localparam int          EV_INTERRUPT_REQUEST_THREE       = 2;
    localparam int          EV_INTERRUPT_REQUEST_ZERO       = 3;
endpackage

/* core/quad_interval_timer_core.sv */
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module quad_interval_timer_core
    import qtimer_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              clk_en_i,
    input  wire logic              timer_reference_clock_i,
    input  wire logic              timer2_pin_signal_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic                   interrupt_request_eight_o,
    output logic                   refresh_request_o,
    output logic                   interrupt_request_three_o,
    output logic                   interrupt_request_zero_o,
    output logic                   timer1_pin_signal_o,
    output logic                   timer2_pin_signal_o,
    output logic                   timer2_pin_signal_oe_o,
    output logic                   timer3_pin_signal_o,
    output logic                   irq_o
);
    logic [1:0]  ref_sync_reg;
    logic        ref_prev_reg;
    logic [1:0]  t2_sync_reg;
    logic        ref_rise;
    logic        ref_fall;
    logic        acc;
    logic        wr_done;
    logic        rd_done;
    logic [31:0] rd_data;
    logic        bad_addr;
    logic        is_cnt;
    logic [1:0]  idx;
    logic [7:0]  wbyte;
    logic [7:0]  ctrl_reg;
    logic [NUM_EV-1:0] stat_reg;
    logic [NUM_EV-1:0] stat_next;
    logic [NUM_EV-1:0] en_reg;
    logic [NUM_EV-1:0] ev;
    logic [NUM_TIMERS-1:0] gate_vec;
    logic [NUM_TIMERS-1:0] prog;
    logic [NUM_TIMERS-1:0] latch_cnt;
    logic [NUM_TIMERS-1:0] latch_st;
    logic [NUM_TIMERS-1:0] dwr;
    logic [NUM_TIMERS-1:0] drd;
    logic [NUM_TIMERS-1:0] out_prev_reg;
    // Per-counter state, indexed by timer number
    logic [5:0]  cw_reg     [NUM_TIMERS];
    logic [7:0]  cr_lo_reg  [NUM_TIMERS];
    logic [7:0]  cr_hi_reg  [NUM_TIMERS];
    logic [15:0] ce_reg     [NUM_TIMERS];
    logic [15:0] ol_reg     [NUM_TIMERS];
    logic [7:0]  st_reg     [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] out_reg;
    logic [NUM_TIMERS-1:0] null_reg;
    logic [NUM_TIMERS-1:0] latched_reg;
    logic [NUM_TIMERS-1:0] st_latched_reg;
    logic [NUM_TIMERS-1:0] load_pend_reg;
    logic [NUM_TIMERS-1:0] run_reg;
    logic [NUM_TIMERS-1:0] wr_hi_reg;
    logic [NUM_TIMERS-1:0] rd_hi_reg;
    logic [NUM_TIMERS-1:0] gate_s_reg;
    logic [NUM_TIMERS-1:0] gate_old_reg;

    // Byte the counter presents on a read; only one latch byte at a time
    function automatic logic [7:0] cnt_byte(input logic [1:0] i);
        logic [15:0] view;
        view = latched_reg[i] ? ol_reg[i] : ce_reg[i];
        if (st_latched_reg[i]) begin
            cnt_byte = st_reg[i];
        end else if (cw_reg[i][5:4] == RW_HIGH || (cw_reg[i][5:4] == RW_BOTH && rd_hi_reg[i])) begin
            cnt_byte = view[15:8];
        end else begin
            cnt_byte = view[7:0];
        end
    endfunction

    // Reference clock and timer 2 pin come from outside: two flops first
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ref_sync_reg <= 2'h0;
            ref_prev_reg <= 1'b0;
            t2_sync_reg  <= 2'h3;
        end else if (clk_en_i) begin
            ref_sync_reg <= {ref_sync_reg[0], timer_reference_clock_i};
            ref_prev_reg <= ref_sync_reg[1];
            t2_sync_reg  <= {t2_sync_reg[0], timer2_pin_signal_i};
        end
    end
    assign ref_rise = ref_sync_reg[1] & ~ref_prev_reg;
    assign ref_fall = ~ref_sync_reg[1] & ref_prev_reg;

    // APB: one wait state, effects at the completing edge
    assign acc     = psel_i & penable_i;
    assign wr_done = acc & pready_o & pwrite_i;
    assign rd_done = acc & pready_o & ~pwrite_i;
    assign wbyte   = pwdata_i[7:0];
    assign is_cnt  = (paddr_i <= OFF_CNT_LAST) && (paddr_i[1:0] == 2'h0);
    assign idx     = paddr_i[3:2];

    // Address decode and read mux
    always_comb begin
        rd_data  = 32'h0;
        bad_addr = 1'b0;
        if (is_cnt) begin
            rd_data = {24'h0, cnt_byte(idx)};
        end else if (paddr_i == OFF_CTRL) begin
            rd_data = {24'h0, ctrl_reg};
        end else if (paddr_i == OFF_INT_STAT) begin
            rd_data = {28'h0, stat_reg};
        end else if (paddr_i == OFF_INT_EN) begin
            rd_data = {28'h0, en_reg};
        end else if (paddr_i == OFF_CW1 || paddr_i == OFF_CW2 || paddr_i == OFF_INT_CLR) begin
            rd_data = 32'h0;
        end else begin
            bad_addr = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else if (clk_en_i) begin
            if (acc && !pready_o) begin
                pready_o  <= 1'b1;
                pslverr_o <= bad_addr;
                prdata_o  <= pwrite_i ? 32'h0 : rd_data;
            end else begin
                pready_o  <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    // Command decode per counter; control word two reaches only timer 3
    always_comb begin
        prog      = '0;
        latch_cnt = '0;
        latch_st  = '0;
        dwr       = '0;
        drd       = '0;
        if (is_cnt) begin
            dwr[idx] = wr_done;
            drd[idx] = rd_done;
        end
        if (wr_done && paddr_i == OFF_CW1) begin
            if (wbyte[7:6] == SEL_READBACK) begin
                for (int i = 0; i < 3; i++) begin
                    latch_cnt[i] = wbyte[i+1] & ~wbyte[RB_NCOUNT];
                    latch_st[i]  = wbyte[i+1] & ~wbyte[RB_NSTAT];
                end
            end else if (wbyte[5:4] == RW_LATCH) begin
                latch_cnt[wbyte[7:6]] = 1'b1;
            end else begin
                prog[wbyte[7:6]] = 1'b1;
            end
        end
        if (wr_done && paddr_i == OFF_CW2) begin
            if (wbyte[7:6] == SEL_READBACK) begin
                latch_cnt[3] = wbyte[1] & ~wbyte[RB_NCOUNT];
                latch_st[3]  = wbyte[1] & ~wbyte[RB_NSTAT];
            end else if (wbyte[5:4] == RW_LATCH) begin
                latch_cnt[3] = 1'b1;
            end else begin
                prog[3] = 1'b1;
            end
        end
    end

    // Gates: timers 0 and 1 always enabled, 2 and 3 from the control port
    assign gate_vec = {ctrl_reg[CTRL_GATE3], ctrl_reg[CTRL_GATE2], 2'b11};

    // Counter core: reference edges first, bus actions last so they win
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                cw_reg[i]    <= 6'h0;
                cr_lo_reg[i] <= 8'h0;
                cr_hi_reg[i] <= 8'h0;
                ce_reg[i]    <= 16'h0;
                ol_reg[i]    <= 16'h0;
                st_reg[i]    <= 8'h0;
            end
            out_reg        <= '0;
            null_reg       <= '0;
            latched_reg    <= '0;
            st_latched_reg <= '0;
            load_pend_reg  <= '0;
            run_reg        <= '0;
            wr_hi_reg      <= '0;
            rd_hi_reg      <= '0;
            gate_s_reg     <= '0;
            gate_old_reg   <= '0;
        end else if (clk_en_i) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (ref_rise) begin
                    gate_s_reg[i] <= gate_vec[i];
                end
                if (ref_fall) begin
                    gate_old_reg[i] <= gate_s_reg[i];
                    if (load_pend_reg[i] || (cw_reg[i][2] && run_reg[i] && gate_s_reg[i] && !gate_old_reg[i])) begin
                        ce_reg[i]        <= {cr_hi_reg[i], cr_lo_reg[i]};
                        null_reg[i]      <= 1'b0;
                        load_pend_reg[i] <= 1'b0;
                        run_reg[i]       <= 1'b1;
                    end else if (run_reg[i] && gate_s_reg[i]) begin
                        // Periodic modes reload from the hold bytes at one
                        if (cw_reg[i][2] && ce_reg[i] == 16'h0001) begin
                            ce_reg[i]  <= {cr_hi_reg[i], cr_lo_reg[i]};
                            out_reg[i] <= 1'b1;
                        end else begin
                            ce_reg[i] <= ce_reg[i] - 16'h0001;
                            if (cw_reg[i][2] && ce_reg[i] == 16'h0002) begin
                                out_reg[i] <= 1'b0;
                            end else if (!cw_reg[i][2] && ce_reg[i] == 16'h0001) begin
                                out_reg[i] <= 1'b1;
                            end
                        end
                    end
                    if (cw_reg[i][2] && !gate_s_reg[i]) begin
                        out_reg[i] <= 1'b1;
                    end
                end
                if (prog[i]) begin
                    cw_reg[i]         <= wbyte[5:0];
                    cr_lo_reg[i]      <= 8'h0;
                    cr_hi_reg[i]      <= 8'h0;
                    out_reg[i]        <= (wbyte[3:1] != MODE_TERMINAL);
                    null_reg[i]       <= 1'b1;
                    run_reg[i]        <= 1'b0;
                    load_pend_reg[i]  <= 1'b0;
                    wr_hi_reg[i]      <= 1'b0;
                    rd_hi_reg[i]      <= 1'b0;
                    latched_reg[i]    <= 1'b0;
                    st_latched_reg[i] <= 1'b0;
                end
                if (latch_cnt[i] && !latched_reg[i]) begin
                    ol_reg[i]      <= ce_reg[i];
                    latched_reg[i] <= 1'b1;
                end
                if (latch_st[i] && !st_latched_reg[i]) begin
                    st_reg[i]         <= {out_reg[i], null_reg[i], cw_reg[i]};
                    st_latched_reg[i] <= 1'b1;
                end
                // Host data lands only in the hold bytes
                if (dwr[i]) begin
                    null_reg[i] <= 1'b1;
                    if (cw_reg[i][5:4] == RW_LOW) begin
                        cr_lo_reg[i]     <= wbyte;
                        load_pend_reg[i] <= 1'b1;
                    end else if (cw_reg[i][5:4] == RW_HIGH) begin
                        cr_hi_reg[i]     <= wbyte;
                        load_pend_reg[i] <= 1'b1;
                    end else if (!wr_hi_reg[i]) begin
                        cr_lo_reg[i] <= wbyte;
                        wr_hi_reg[i] <= 1'b1;
                        if (cw_reg[i][3:1] == MODE_TERMINAL) begin
                            run_reg[i] <= 1'b0;
                            out_reg[i] <= 1'b0;
                        end
                    end else begin
                        cr_hi_reg[i]     <= wbyte;
                        wr_hi_reg[i]     <= 1'b0;
                        load_pend_reg[i] <= 1'b1;
                    end
                end
                // Reads release status first, then the count latch
                if (drd[i]) begin
                    if (st_latched_reg[i]) begin
                        st_latched_reg[i] <= 1'b0;
                    end else if (cw_reg[i][5:4] == RW_BOTH) begin
                        rd_hi_reg[i] <= ~rd_hi_reg[i];
                        if (rd_hi_reg[i]) begin
                            latched_reg[i] <= 1'b0;
                        end
                    end else begin
                        latched_reg[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // Control port; gates low after reset
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (clk_en_i && wr_done && paddr_i == OFF_CTRL) begin
            ctrl_reg <= wbyte;
        end
    end

    // Timer output events
    assign ev[EV_INTERRUPT_REQUEST_EIGHT]    = out_reg[0] & ~out_prev_reg[0];
    assign ev[EV_REFRESH] = out_reg[1] & ~out_prev_reg[1] & ctrl_reg[CTRL_REF_EN];
    assign ev[EV_INTERRUPT_REQUEST_THREE]    = ~t2_sync_reg[1];
    assign ev[EV_INTERRUPT_REQUEST_ZERO]    = out_reg[3] & ~out_prev_reg[3];

    // Pins and request outputs, all registered
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            out_prev_reg              <= '0;
            interrupt_request_eight_o <= 1'b0;
            refresh_request_o         <= 1'b0;
            interrupt_request_three_o <= 1'b0;
            interrupt_request_zero_o  <= 1'b0;
            timer1_pin_signal_o       <= 1'b1;
            timer2_pin_signal_o       <= 1'b0;
            timer2_pin_signal_oe_o    <= 1'b0;
            timer3_pin_signal_o       <= 1'b1;
        end else if (clk_en_i) begin
            out_prev_reg              <= out_reg;
            interrupt_request_eight_o <= ev[EV_INTERRUPT_REQUEST_EIGHT];
            refresh_request_o         <= ev[EV_REFRESH];
            interrupt_request_three_o <= ev[EV_INTERRUPT_REQUEST_THREE];
            interrupt_request_zero_o  <= ev[EV_INTERRUPT_REQUEST_ZERO];
            timer1_pin_signal_o       <= ~out_reg[1];
            timer2_pin_signal_oe_o    <= out_reg[2];
            timer3_pin_signal_o       <= ~out_reg[3];
        end
    end

    // Sticky status: a set in the clearing cycle survives
    assign stat_next = (stat_reg & ~((wr_done && paddr_i == OFF_INT_CLR) ? pwdata_i[NUM_EV-1:0] : '0)) | ev;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            stat_reg <= '0;
            en_reg   <= '0;
            irq_o    <= 1'b0;
        end else if (clk_en_i) begin
            stat_reg <= stat_next;
            irq_o    <= |(stat_next & en_reg);
            if (wr_done && paddr_i == OFF_INT_EN) begin
                en_reg <= pwdata_i[NUM_EV-1:0];
            end
        end
    end

    sequence s_out0_rise;
        clk_en_i && $rose(out_reg[0]);
    endsequence
    sequence s_out3_rise;
        clk_en_i && $rose(out_reg[3]);
    endsequence

    property p_interrupt_request_eight;
        @(posedge sys_clk_i) disable iff (!rstn_i) s_out0_rise |=> interrupt_request_eight_o;
    endproperty
    a_interrupt_request_eight: assert property (p_interrupt_request_eight) else $error("irq eight missing");

    property p_refresh;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            clk_en_i && !ctrl_reg[CTRL_REF_EN] |=> !refresh_request_o;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh while disabled");

    property p_interrupt_request_three;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            clk_en_i && !t2_sync_reg[1] |=> interrupt_request_three_o;
    endproperty
    a_interrupt_request_three: assert property (p_interrupt_request_three) else $error("irq three missing");

    property p_interrupt_request_zero;
        @(posedge sys_clk_i) disable iff (!rstn_i) s_out3_rise |=> interrupt_request_zero_o;
    endproperty
    a_interrupt_request_zero: assert property (p_interrupt_request_zero) else $error("irq zero missing");

    property p_pin3;
        @(posedge sys_clk_i) disable iff (!rstn_i) clk_en_i |=> timer3_pin_signal_o == !$past(out_reg[3]);
    endproperty
    a_pin3: assert property (p_pin3) else $error("timer 3 pin not inverted");

    property p_clear;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            clk_en_i && prog[1] && !dwr[1] |=> cr_lo_reg[1] == 8'h0 && cr_hi_reg[1] == 8'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("hold bytes not cleared");

    property p_load;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            clk_en_i && ref_fall && load_pend_reg[0]
            |=> ce_reg[0] == {$past(cr_hi_reg[0]), $past(cr_lo_reg[0])};
    endproperty
    a_load: assert property (p_load) else $error("count not loaded");

    property p_gate;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            clk_en_i && ref_rise |=> gate_s_reg[2] == $past(ctrl_reg[CTRL_GATE2]) && gate_s_reg[0];
    endproperty
    a_gate: assert property (p_gate) else $error("gate sample wrong");

    property p_hold;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            clk_en_i && latched_reg[2] && !drd[2] && !prog[2] |=> $stable(ol_reg[2]) && latched_reg[2];
    endproperty
    a_hold: assert property (p_hold) else $error("latch not frozen");
endmodule

/* dv/pin_env.sv */
`timescale 1ns/1ps
// Far side of the timer 2 pin: open drain with a weak pull-up and an outside low driver
module pin_env (
    input  wire logic oe_i,
    input  wire logic pull_low_i,
    output logic      pin_o
);
    // Pull-up wins only when nobody sinks the line
    assign pin_o = (oe_i || pull_low_i) ? 1'b0 : 1'b1;
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import qtimer_pkg::*;
    logic        clk, rstn, refc, pl, psel, pen, pwr, rdy, serr, se, interrupt_request_eight, rfr, interrupt_request_three, interrupt_request_zero, t1p, t2p, t2oe, t3p, irq, pin;
    logic [7:0]  pa;
    logic [31:0] pwd, prd, rd, c, v;
    int          err_total, checked, cyc, n8, nr, n0;

    quad_interval_timer_core u_dut (.sys_clk_i(clk), .rstn_i(rstn), .clk_en_i(1'b1), .timer_reference_clock_i(refc),
        .timer2_pin_signal_i(pin), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(rdy), .pslverr_o(serr), .interrupt_request_eight_o(interrupt_request_eight), .refresh_request_o(rfr),
        .interrupt_request_three_o(interrupt_request_three), .interrupt_request_zero_o(interrupt_request_zero), .timer1_pin_signal_o(t1p),
        .timer2_pin_signal_o(t2p), .timer2_pin_signal_oe_o(t2oe), .timer3_pin_signal_o(t3p), .irq_o(irq));
    pin_env u_pin (.oe_i(t2oe), .pull_low_i(pl), .pin_o(pin));

    // System clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Event pulses are one cycle wide, so count them at every edge; also bound the run
    always @(posedge clk) begin
        cyc++;
        n8 += (interrupt_request_eight === 1'b1);
        nr += (rfr === 1'b1);
        n0 += (interrupt_request_zero === 1'b1);
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        se = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Reference pulses kept slow, since the synchroniser needs two system cycles per phase
    task automatic pulses(input int n);
        repeat (n) begin
            refc <= 1'b1;
            repeat (5) @(posedge clk);
            refc <= 1'b0;
            repeat (5) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    function automatic logic [31:0] cw(input logic [1:0] sel, input logic [1:0] rw);
        return {24'h0, sel, rw, MODE_TERMINAL, 1'b0};
    endfunction

    task end_of_test;
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        {rstn, refc, pl, psel, pen, pwr} = '0;
        pa = '0;
        pwd = '0;
        c = $urandom(32'h616019f3);
        c = 32'h10 + ($urandom % 64);
        v = $urandom % 16;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({t1p, t3p, interrupt_request_eight, rfr, interrupt_request_zero, irq, t2oe, t2p}, 32'hc0);
        apb(1'b0, OFF_CTRL, 0);
        chk(rd, 0);
        apb(1'b0, 8'hfc, 0);
        chk(se, 1);
        apb(1'b1, OFF_INT_EN, v);
        apb(1'b0, OFF_INT_EN, 0);
        chk(rd, v);
        apb(1'b1, OFF_INT_EN, 0);
        // Latched count stays frozen while counting goes on, then follows again
        apb(1'b1, OFF_CW1, cw(0, RW_LOW));
        apb(1'b1, 8'h00, c);
        pulses(3);
        apb(1'b1, OFF_CW1, cw(0, RW_LATCH));
        pulses(3);
        apb(1'b0, 8'h00, 0);
        chk(rd, c - 2);
        apb(1'b1, OFF_CW1, cw(0, RW_LATCH));
        apb(1'b0, 8'h00, 0);
        chk(rd, c - 5);
        // Timer 0 terminal count, then mask and clear of the interrupt
        apb(1'b1, OFF_CW1, cw(0, RW_LOW));
        apb(1'b1, 8'h00, 1);
        pulses(3);
        chk(n8, 1);
        apb(1'b0, OFF_INT_STAT, 0);
        chk({rd[EV_INTERRUPT_REQUEST_EIGHT], irq}, 2);
        apb(1'b1, OFF_INT_EN, 1);
        repeat (2) @(posedge clk);
        chk(irq, 1);
        apb(1'b1, OFF_INT_CLR, 1);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        // Refresh request and read-back status of timer 1
        apb(1'b1, OFF_CTRL, 2);
        apb(1'b1, OFF_CW1, cw(1, RW_LOW));
        apb(1'b1, 8'h04, 1);
        pulses(3);
        chk(nr, 1);
        chk(t1p, 0);
        apb(1'b1, OFF_CW1, 8'he4);
        apb(1'b0, 8'h04, 0);
        chk(rd, 32'h90);
        // Both count bytes reach the counter together; gate 2 still closed
        apb(1'b1, OFF_CW1, cw(2, RW_BOTH));
        apb(1'b1, 8'h08, 8'h34);
        apb(1'b1, 8'h08, 8'h12);
        pulses(1);
        apb(1'b1, OFF_CW1, cw(2, RW_LATCH));
        apb(1'b0, 8'h08, 0);
        chk(rd, 32'h34);
        apb(1'b0, 8'h08, 0);
        chk(rd, 32'h12);
        // A stale high byte would keep the output low here
        apb(1'b1, OFF_CW1, cw(2, RW_LOW));
        apb(1'b1, 8'h08, 2);
        apb(1'b1, OFF_CTRL, 3);
        pulses(3);
        chk({t2oe, interrupt_request_three}, 3);
        apb(1'b1, OFF_CW1, cw(2, RW_LOW));
        repeat (5) @(posedge clk);
        chk(interrupt_request_three, 0);
        pl <= 1'b1;
        repeat (5) @(posedge clk);
        chk(interrupt_request_three, 1);
        pl <= 1'b0;
        // Timer 3 through the second control word, held by its gate
        apb(1'b1, OFF_CW2, cw(0, RW_LOW));
        apb(1'b1, 8'h0c, 1);
        pulses(3);
        chk(n0, 0);
        chk(t3p, 1);
        apb(1'b1, OFF_CTRL, 8'h43);
        pulses(2);
        chk(n0, 1);
        chk(t3p, 0);
        // Rate generator on timer 1, count 3: a rising edge every third pulse
        apb(1'b1, OFF_CW1, 8'h54);
        apb(1'b1, 8'h04, 3);
        pulses(7);
        chk(nr, 3);
        // High byte only: the low hold byte was cleared, so one decrement borrows
        apb(1'b1, OFF_CW1, 8'ha0);
        apb(1'b1, 8'h08, 8'h05);
        pulses(1);
        apb(1'b0, 8'h08, 0);
        chk(rd, 32'h05);
        pulses(1);
        apb(1'b0, 8'h08, 0);
        chk(rd, 32'h04);
        // Read-back through the second control word latches timer 3 status
        apb(1'b1, OFF_CW2, 8'he2);
        apb(1'b0, 8'h0c, 0);
        chk(rd, 32'h90);
        end_of_test();
    end
endmodule
